// *** bench/bml_link_asserts.sv ***
// checker for the register link between host end and monitor end
// assumes one hclk, async active-low hresetn, instanced beside the link
`default_nettype none
module bml_link_asserts
  import bml_pkg::*;
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       req,
  input wire logic       wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       alert
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic clr_take;
  assign clr_take = req && !ack && wr && addr == BML_A_STAT && wdata[BML_STAT_READY_BIT];

  sequence s_take;
    req && !ack;
  endsequence
  sequence s_read;
    s_take ##0 !wr ##1 ack;
  endsequence

  a_ack_after_take: assert property (s_take |=> ack)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without request");
  a_req_held: assert property (s_take |=> req && $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("request changed before ack");
  a_read_close: assert property (s_read |=> !req && !ack)
    else $error("read not closed after ack");
  a_rdata_hold: assert property ($changed(rdata) |-> ack && !wr)
    else $error("read data changed outside read ack");
  a_alert_holds: assert property (alert && !clr_take && !$past(clr_take) |=> alert)
    else $error("alert dropped without clear");
  a_alert_drop: assert property ($fell(alert) |-> $past(clr_take, 1) || $past(clr_take, 2))
    else $error("alert fell without clear write");
endmodule : bml_link_asserts
`default_nettype wire

// *** bench/test_battery_monitor_measurement_scheduler.sv ***
// testbench: AHB master driving host end, monitor end fed with samples
// assumes zero-wait host slave and a shortened tick
`default_nettype none
module test_battery_monitor_measurement_scheduler
  import bml_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 20;
  logic                                 hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]                          haddr, hwdata, hrdata, r;
  logic [1:0]                           htrans;
  logic [2:0]                           hsize;
  logic signed [BML_CC_W-1:0]           cc_sample;
  logic [BML_CELLS-1:0][BML_ADC_W-1:0]  cell_code;
  logic [BML_TEMPS-1:0][BML_ADC_W-1:0]  therm_code, die_code;
  logic [7:0]                           b;
  logic [15:0]                          w, s;
  int                                   n_errors, n_tests;

  bml_link_if bml_link_if_inst();
  bml_monitor #(.TICK_CYCLES(TK)) bml_monitor_inst(.hclk(hclk), .hresetn(hresetn), .link(bml_link_if_inst),
    .cc_sample(cc_sample), .cell_code(cell_code), .therm_code(therm_code), .die_code(die_code));
  bml_host bml_host_inst(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .link(bml_link_if_inst));
  bml_link_asserts bml_link_asserts_inst(.hclk(hclk), .hresetn(hresetn), .req(bml_link_if_inst.req),
    .wr(bml_link_if_inst.wr), .addr(bml_link_if_inst.addr), .wdata(bml_link_if_inst.wdata),
    .ack(bml_link_if_inst.ack), .rdata(bml_link_if_inst.rdata), .alert(bml_link_if_inst.alert));

  task automatic results();
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ready();
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      i++;
      if (i > 100)
      begin
        n_errors++;
        results();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= BML_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask : ahb

  // one device access through the command register, then poll busy
  task automatic dev(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    ahb(1'b1, BML_H_CMD, {15'h0, wr, a, d});
    i = 0;
    do
    begin
      ahb(1'b0, BML_H_STAT, 32'h0);
      i++;
    end
    while (r[BML_HS_BUSY_BIT] !== 1'b0 && i < 50);
    if (i >= 50)
    begin
      n_errors++;
      results();
    end
    b = r[15:8];
  endtask : dev

  task automatic rd16(input logic [7:0] a);
    dev(1'b0, a, 8'h00);
    w[15:8] = b;
    dev(1'b0, a + 8'h01, 8'h00);
    w[7:0] = b;
  endtask : rd16

  task automatic wait_alert();
    int i;
    i = 0;
    do
    begin
      ahb(1'b0, BML_H_STAT, 32'h0);
      i++;
    end
    while (r[BML_HS_ALERT_BIT] !== 1'b1 && i < 4 * TK);
    check(r[BML_HS_ALERT_BIT], 1'b1);
  endtask : wait_alert

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    results();
  end

  initial
  begin
    n_errors = 0;
    n_tests = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cc_sample = 16'sh0;
    for (int i = 0; i < BML_CELLS; i++)
      cell_code[i] = 14'(1000 + i * 100);
    for (int i = 0; i < BML_TEMPS; i++)
    begin
      die_code[i] = 14'(200 + i);
      therm_code[i] = 14'(3000 + i * 7);
    end
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    dev(1'b0, BML_A_CTRL, 8'h00);
    check(b, 8'h00);
    dev(1'b0, 8'h20, 8'h00);
    check(b, 8'h00);
    ahb(1'b0, 8'h08, 32'h0);
    check(r, 32'h0);
    repeat (2 * TK) @(posedge hclk);
    for (int t = 0; t < BML_TEMPS; t++)
    begin
      rd16(BML_A_TS1_HI + 8'(2 * t));
      check(w, {2'b00, die_code[t]});
    end
    dev(1'b1, BML_A_CTRL, 8'h08);
    dev(1'b0, BML_A_CTRL, 8'h00);
    check(b, 8'h08);
    repeat (9 * TK) @(posedge hclk);
    for (int t = 0; t < BML_TEMPS; t++)
    begin
      rd16(BML_A_TS1_HI + 8'(2 * t));
      check(w, {2'b00, therm_code[t]});
    end
    for (int k = 0; k < 2; k++)
    begin
      s = 16'h0;
      for (int i = 0; i < BML_CELLS; i++)
        s = s + 16'(cell_code[i]);
      rd16(BML_A_BAT_HI);
      check(w, {2'b00, s[15:2]});
      check(r[15:8], s[9:2]);
      cell_code[0] <= cell_code[0] + 14'h0190;
      repeat (2 * TK) @(posedge hclk);
    end
    cc_sample <= 16'sd3;
    dev(1'b1, BML_A_CTRL, 8'h20);
    wait_alert();
    rd16(BML_A_CC_HI);
    check(w, 16'h003C);
    dev(1'b0, BML_A_CTRL, 8'h00);
    check(b, 8'h00);
    check(bml_link_if_inst.alert, 1'b1);
    dev(1'b1, BML_A_STAT, 8'h01);
    check(bml_link_if_inst.alert, 1'b0);
    repeat (3 * TK) @(posedge hclk);
    check(bml_link_if_inst.alert, 1'b0);
    cc_sample <= 16'sd1000;
    dev(1'b1, BML_A_CTRL, 8'h40);
    repeat (3 * TK) @(posedge hclk);
    dev(1'b0, BML_A_CC_HI, 8'h00);
    check(b, 8'h4E);
    cc_sample <= 16'sd1500;
    repeat (3 * TK) @(posedge hclk);
    dev(1'b0, BML_A_CC_LO, 8'h00);
    check(b, 8'h20);
    rd16(BML_A_CC_HI);
    check(w, 16'h7530);
    cc_sample <= -16'sd2000;
    repeat (3 * TK) @(posedge hclk);
    rd16(BML_A_CC_HI);
    check(w, 16'h8000);
    dev(1'b1, BML_A_STAT, 8'h01);
    wait_alert();
    dev(1'b1, BML_A_CTRL, 8'h00);
    repeat (2 * TK) @(posedge hclk);
    dev(1'b1, BML_A_STAT, 8'h01);
    repeat (3 * TK) @(posedge hclk);
    check(bml_link_if_inst.alert, 1'b0);
    check(hresp, 1'b0);
    results();
  end
endmodule : test_battery_monitor_measurement_scheduler
`default_nettype wire

// *** logic/bml_host.sv ***
// host end: AHB-Lite slave that issues register accesses over the link
// assumes one AHB master, single word transfers, same hclk as the monitor
`default_nettype none
module bml_host
  import bml_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  bml_link_if.host         link
);

  typedef enum logic [1:0] {
    BML_H_IDLE = 2'b01,
    BML_H_WAIT = 2'b10
  } bml_host_state_t;

  logic            dp_wr_q;
  logic            dp_rd_q;
  logic [7:0]      dp_addr_q;
  bml_host_state_t st_q;
  logic            req_q;
  logic            wr_q;
  logic [7:0]      addr_q;
  logic [7:0]      wdata_q;
  logic [7:0]      last_q;
  logic [31:0]     rdata_q;
  logic            launch;
  logic            take;

  assign take      = hsel && hready && (htrans == BML_HTRANS_NONSEQ);
  assign launch    = dp_wr_q && (dp_addr_q == BML_H_CMD) && (st_q == BML_H_IDLE);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_q   <= 1'b0;
      dp_rd_q   <= 1'b0;
      dp_addr_q <= 8'h00;
    end
    else
    begin
      dp_wr_q   <= take && hwrite;
      dp_rd_q   <= take && !hwrite;
      dp_addr_q <= haddr[7:0];
    end
  end

  // read data is registered so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (take && !hwrite && (haddr[7:0] == BML_H_STAT))
    begin
      // a command in its data phase already counts as busy, so a poll right behind it waits
      rdata_q <= {16'h0000, last_q, 6'h00, link.alert, (st_q == BML_H_WAIT) || launch};
    end
    else
    begin
      rdata_q <= 32'h00000000;
    end
  end

  // link sequencer: req held until ack
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q    <= BML_H_IDLE;
      req_q   <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= 8'h00;
      wdata_q <= 8'h00;
      last_q  <= 8'h00;
    end
    else
    begin
      case (st_q)
        BML_H_IDLE:
        begin
          if (launch)
          begin
            st_q    <= BML_H_WAIT;
            req_q   <= 1'b1;
            wr_q    <= hwdata[BML_CMD_WR_BIT];
            addr_q  <= hwdata[15:8];
            wdata_q <= hwdata[7:0];
            // a single-shot request never carries the continuous enable
            if (hwdata[15:8] == BML_A_CTRL && hwdata[BML_CTRL_TRIG_BIT])
            begin
              wdata_q[BML_CTRL_CCEN_BIT] <= 1'b0;
            end
          end
        end
        BML_H_WAIT:
        begin
          if (link.ack)
          begin
            st_q   <= BML_H_IDLE;
            req_q  <= 1'b0;
            last_q <= wr_q ? last_q : link.rdata;
          end
        end
        default:
        begin
          st_q  <= BML_H_IDLE;
          req_q <= 1'b0;
        end
      endcase
    end
  end

  assign link.req   = req_q;
  assign link.wr    = wr_q;
  assign link.addr  = addr_q;
  assign link.wdata = wdata_q;

endmodule : bml_host
`default_nettype wire

// *** logic/bml_link_if.sv ***
// register access link between the host end and the monitor end
// assumes both ends share one clock; req is held until ack
`default_nettype none
interface bml_link_if;
  logic       req;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       alert;
  modport dev  (input req, wr, addr, wdata, output ack, rdata, alert);
  modport host (output req, wr, addr, wdata, input ack, rdata, alert);
endinterface : bml_link_if
`default_nettype wire

// *** logic/bml_monitor.sv ***
// monitor end: coulomb counter, temperature and pack sum scheduling, registers
// assumes sense, cell and temperature samples arrive synchronous to hclk
// What this block does
// - integrate sense samples into 16-bit charge per window
// - continuous mode: new result and ready each window
// - ready flag setting drives alert high
// - continuous enable bit starts back-to-back conversions
// - single shot: one window, then ready
// - host keeps enable 0, sets trigger
// - result is signed 16-bit, saturated
// - select 1: thermistor readings to temperature registers
// - select 0: die readings to temperature registers
// - new source appears within temperature interval
// - temperature results are 14-bit converter codes
// - select picks the source for all three temperature registers
// - sum all cells, divide by four, 16 bits
// - pack sum lsb is four converter lsbs
// - full update with pack sum each interval
// - temperatures update every eighth interval
// - host derives stack gain from readings
// - host refreshes gain after large voltage change
// - high then low read returns one snapshot
// - alert holds until host clears flag
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`default_nettype none
module bml_monitor
  import bml_pkg::*;
#(
  parameter int TICK_CYCLES = BML_TICK_CYCLES
)(
  input  wire logic                                 hclk,
  input  wire logic                                 hresetn,
  bml_link_if.dev                                   link,
  input  wire logic signed [BML_CC_W-1:0]           cc_sample,
  input  wire logic [BML_CELLS-1:0][BML_ADC_W-1:0]  cell_code,
  input  wire logic [BML_TEMPS-1:0][BML_ADC_W-1:0]  therm_code,
  input  wire logic [BML_TEMPS-1:0][BML_ADC_W-1:0]  die_code
);
  typedef enum logic [1:0] {
    BML_CC_IDLE = 2'b01,
    BML_CC_RUN  = 2'b10
  } bml_cc_state_t;
  function automatic logic [17:0] sum_cells(input logic [BML_CELLS-1:0][BML_ADC_W-1:0] c);
    logic [17:0] s;
    s = 18'h00000;
    for (int i = 0; i < BML_CELLS; i++)
    begin
      s = s + {4'h0, c[i]};
    end
    return s;
  endfunction : sum_cells
  function automatic logic [BML_CC_W-1:0] sat16(input logic signed [31:0] v);
    return (v > 32'sh00007FFF) ? 16'h7FFF : (v < -32'sh00008000) ? 16'h8000 : v[15:0];
  endfunction : sat16
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic [2:0]  temp_cnt_q;
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  // master interval timer, temperatures on every eighth tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_q <= 32'h00000000;
      temp_cnt_q <= 3'h0;
    end
    else
    begin
      tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
      if (tick)
      begin
        temp_cnt_q <= (temp_cnt_q == 3'(BML_TEMP_TICKS - 1)) ? 3'h0 : temp_cnt_q + 3'h1;
      end
    end
  end
  logic continuous_count_enable_q;
  logic trig_q;
  logic tsel_q;
  logic ready_q;
  logic cc_done;
  logic wr_ctrl;
  logic wr_stat;
  logic acc_take;
  assign acc_take = link.req && !link.ack;
  assign wr_ctrl  = acc_take && link.wr && (link.addr == BML_A_CTRL);
  assign wr_stat  = acc_take && link.wr && (link.addr == BML_A_STAT);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      continuous_count_enable_q <= 1'b0;
      tsel_q  <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      continuous_count_enable_q <= link.wdata[BML_CTRL_CCEN_BIT];
      tsel_q  <= link.wdata[BML_CTRL_TSEL_BIT];
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trig_q <= 1'b0;
    end
    else if (cc_done)
    begin
      trig_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      trig_q <= link.wdata[BML_CTRL_TRIG_BIT] && !link.wdata[BML_CTRL_CCEN_BIT];
    end
  end
  // coulomb counter
  bml_cc_state_t      cc_state_q;
  logic [31:0]        cc_cnt_q;
  logic signed [31:0] acc_q;
  logic signed [31:0] acc_d;
  logic [15:0]        cc_res_q;
  logic               win_end;
  assign acc_d   = acc_q + 32'(cc_sample);
  assign win_end = (cc_cnt_q == 32'(TICK_CYCLES - 1));
  assign cc_done = (cc_state_q == BML_CC_RUN) && win_end;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cc_state_q <= BML_CC_IDLE;
      cc_cnt_q   <= 32'h00000000;
      acc_q      <= 32'sh00000000;
      cc_res_q   <= 16'h0000;
    end
    else
    begin
      case (cc_state_q)
        BML_CC_IDLE:
        begin
          cc_cnt_q <= 32'h00000000;
          acc_q    <= 32'sh00000000;
          if (continuous_count_enable_q || trig_q)
          begin
            cc_state_q <= BML_CC_RUN;
          end
        end
        BML_CC_RUN:
        begin
          if (win_end)
          begin
            cc_res_q <= sat16(acc_d);
            cc_cnt_q <= 32'h00000000;
            acc_q    <= 32'sh00000000;
            cc_state_q <= continuous_count_enable_q ? BML_CC_RUN : BML_CC_IDLE;
          end
          else
          begin
            cc_cnt_q <= cc_cnt_q + 32'h00000001;
            acc_q    <= acc_d;
          end
        end
        default:
        begin
          cc_state_q <= BML_CC_IDLE;
        end
      endcase
    end
  end
  // ready flag, set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ready_q <= 1'b0;
    end
    else if (cc_done)
    begin
      ready_q <= 1'b1;
    end
    else if (wr_stat && link.wdata[BML_STAT_READY_BIT])
    begin
      ready_q <= 1'b0;
    end
  end
  assign link.alert = ready_q;
  // scheduled results
  logic [BML_TEMPS-1:0][15:0] temp_q;
  logic [15:0]                bat_q;
  logic [17:0]                cell_sum;
  assign cell_sum = sum_cells(cell_code);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bat_q <= 16'h0000;
    end
    else if (tick)
    begin
      bat_q <= cell_sum[17:2];
    end
  end
  generate
    for (genvar t = 0; t < BML_TEMPS; t++)
    begin : g_temp
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          temp_q[t] <= 16'h0000;
        end
        else if (tick && (temp_cnt_q == 3'h0))
        begin
          temp_q[t] <= {2'h0, tsel_q ? therm_code[t] : die_code[t]};
        end
      end
    end
  endgenerate
  // register read with high/low snapshot
  function automatic logic [15:0] pair_word(input logic [7:0] a, input logic [15:0] cc,
                                            input logic [BML_TEMPS-1:0][15:0] ts, input logic [15:0] pack_sum_result);
    case (a[7:1])
      BML_A_CC_HI[7:1]:  return cc;
      BML_A_TS1_HI[7:1]: return ts[0];
      BML_A_TS2_HI[7:1]: return ts[1];
      BML_A_TS3_HI[7:1]: return ts[2];
      BML_A_BAT_HI[7:1]: return pack_sum_result;
      default:           return 16'h0000;
    endcase
  endfunction : pair_word
  logic [15:0] word;
  logic [7:0]  snap_lo_q;
  logic [7:0]  snap_addr_q;
  logic        snap_vld_q;
  logic        ack_q;
  logic [7:0]  rdata_q;
  logic        pair_addr;
  logic [7:0]  rd_byte;
  assign word      = pair_word(link.addr, cc_res_q, temp_q, bat_q);
  assign pair_addr = (link.addr >= BML_A_CC_HI) && (link.addr <= BML_A_LAST);
  assign rd_byte   = (link.addr == BML_A_STAT) ? {7'h00, ready_q} :
                     (link.addr == BML_A_CTRL) ? {1'b0, continuous_count_enable_q, trig_q, 1'b0, tsel_q, 3'h0} :
                     (snap_vld_q && (link.addr == snap_addr_q)) ? snap_lo_q :
                     (link.addr[0] ? word[7:0] : word[15:8]);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      snap_lo_q   <= 8'h00;
      snap_addr_q <= 8'h00;
      snap_vld_q  <= 1'b0;
    end
    else if (acc_take)
    begin
      snap_vld_q  <= !link.wr && pair_addr && !link.addr[0];
      snap_lo_q   <= word[7:0];
      snap_addr_q <= link.addr | 8'h01;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      ack_q <= acc_take;
      if (acc_take && !link.wr)
      begin
        rdata_q <= rd_byte;
      end
    end
  end
  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;
endmodule : bml_monitor
`default_nettype wire

// *** logic/bml_pkg.sv ***
// constants shared by both ends of the battery monitor measurement link
// assumes both ends run on the same hclk
`default_nettype none
package bml_pkg;
  // clock and timing
  localparam int BML_CLK_NS      = 10;
  localparam int BML_TICK_MS     = 250;
  localparam int BML_TICK_CYCLES = BML_TICK_MS * 1000000 / BML_CLK_NS;
  localparam int BML_TEMP_S      = 2;
  localparam int BML_TEMP_TICKS  = BML_TEMP_S * 1000 / BML_TICK_MS;
  // widths
  localparam int BML_CELLS   = 15;
  localparam int BML_ADC_W   = 14;
  localparam int BML_CC_W    = 16;
  localparam int BML_TEMPS   = 3;
  // device register addresses, high byte at even address
  localparam logic [7:0] BML_A_STAT   = 8'h00;
  localparam logic [7:0] BML_A_CTRL   = 8'h01;
  localparam logic [7:0] BML_A_CC_HI  = 8'h02;
  localparam logic [7:0] BML_A_CC_LO  = 8'h03;
  localparam logic [7:0] BML_A_TS1_HI = 8'h04;
  localparam logic [7:0] BML_A_TS2_HI = 8'h06;
  localparam logic [7:0] BML_A_TS3_HI = 8'h08;
  localparam logic [7:0] BML_A_BAT_HI = 8'h0A;
  localparam logic [7:0] BML_A_LAST   = 8'h0B;
  // fields
  localparam int BML_STAT_READY_BIT  = 0;
  localparam int BML_CTRL_CCEN_BIT   = 6;
  localparam int BML_CTRL_TRIG_BIT   = 5;
  localparam int BML_CTRL_TSEL_BIT   = 3;
  // host AHB registers
  localparam logic [7:0] BML_H_CMD  = 8'h00;
  localparam logic [7:0] BML_H_STAT = 8'h04;
  localparam int BML_CMD_WR_BIT     = 16;
  localparam int BML_HS_BUSY_BIT    = 0;
  localparam int BML_HS_ALERT_BIT   = 1;
  localparam logic [1:0] BML_HTRANS_NONSEQ = 2'h2;
endpackage : bml_pkg
`default_nettype wire
